// ==== core/rstseq_top.sv ====
// system reset sequencer: source merge, cause flags, ordered release
`timescale 1ns/100ps
`default_nettype none
module rstseq_top (
	input  wire logic        clk_in,
	input  wire logic        reset_in,
	input  wire logic        reset_pin_n_in,
	input  wire logic        supply_good_in,
	input  wire logic        lvd_level_in,
	input  wire logic        lvd_reset_level_in,
	input  wire logic        lvd_reset_sel_in,
	input  wire logic        watchdog_counter_ovf_in,
	input  wire logic        sw_system_reset_request_in,
	input  wire logic        deep_sleep_wake_pin_in,
	input  wire logic        boot_loader_enable_in,
	input  wire logic        pin_reset_control_wr_in,
	input  wire logic        pin_reset_control_in,
	input  wire logic        lvd_irq_enable_in,
	input  wire logic        cause_clear_in,
	output var  logic        sys_reset_out,
	output var  logic        reset_pin_out,
	output var  logic        reset_pin_oe_out,
	output var  logic        regs_init_out,
	output var  logic        clk_release_out,
	output var  logic        run_out,
	output var  logic [31:0] start_addr_out,
	output var  logic [31:0] vector_addr_out,
	output var  logic [5:0]  reset_cause_status_out,
	output var  logic        pin_reset_control_out,
	output var  logic        lvd_irq_out,
	output var  logic        lvd_status_out
);
	typedef struct packed {
		rstseq_pkg::rstseq_state_t      state;
		logic [rstseq_pkg::CNT_W-1:0]   cnt;
		logic [5:0]                     cause;
		logic                           pin_en;
		logic                           por_seen;
		rstseq_pkg::rstseq_ctl_t        ctl;
		logic                           lvd_irq;
		logic                           lvd_stat;
	} rstseq_regs_t;

	rstseq_regs_t        st_r;
	rstseq_regs_t        st_nxt;
	rstseq_pkg::rstseq_src_t src;
	logic [4:0]          raw_s;
	logic                pin_low_s;
	logic                pin_reset_hit;
	logic                any_src;

	// pins and analog levels cross into clk_in before use
	rstseq_sync #(
		.W    (5),
		// idle levels, so no false source shows while the flops fill
		.INIT (5'h00)
	) u_sync (
		.clk_in   (clk_in),
		.reset_in (reset_in),
		.async_in ({~reset_pin_n_in, supply_good_in, lvd_level_in,
			lvd_reset_level_in, deep_sleep_wake_pin_in}),
		.sync_out (raw_s)
	);

	always_comb begin
		pin_low_s     = raw_s[4];
		src.pin_low   = pin_low_s;
		src.por       = 1'b0;
		src.lvd_reset = lvd_reset_sel_in & raw_s[1];
		src.wdt_ovf   = watchdog_counter_ovf_in;
		src.sw_req    = sw_system_reset_request_in;
		src.wake      = raw_s[0];
		// own drive reads back on the pin until pin check lets it go
		pin_reset_hit = st_r.pin_en & src.pin_low
			& (st_r.state != rstseq_pkg::RSTSEQ_POWER_UP)
			& (st_r.state != rstseq_pkg::RSTSEQ_PIN_CHECK);
		any_src = pin_reset_hit | src.lvd_reset | src.wdt_ovf | src.sw_req | src.wake;
	end

	always_comb begin
		st_nxt = st_r;
		st_nxt.ctl.sys_reset     = 1'b1;
		st_nxt.ctl.pin_drive_low = 1'b1;
		st_nxt.ctl.regs_init     = 1'b0;
		st_nxt.ctl.clk_release   = 1'b0;
		st_nxt.ctl.run           = 1'b0;
		st_nxt.ctl.vector_addr   = rstseq_pkg::RESET_VECTOR_ADDR;
		// pin reset enable, software may change it
		if (pin_reset_control_wr_in) begin
			st_nxt.pin_en = pin_reset_control_in;
		end
		// enable gates irq, status always pollable
		st_nxt.lvd_irq  = raw_s[2] & lvd_irq_enable_in;
		st_nxt.lvd_stat = raw_s[2];
		// flags sticky, new sets win over clear
		if (cause_clear_in && st_r.state == rstseq_pkg::RSTSEQ_RUN) begin
			st_nxt.cause = 6'h00;
		end
		st_nxt.cause[rstseq_pkg::CAUSE_PIN]  = st_nxt.cause[rstseq_pkg::CAUSE_PIN] | pin_reset_hit;
		st_nxt.cause[rstseq_pkg::CAUSE_LVD]  = st_nxt.cause[rstseq_pkg::CAUSE_LVD] | src.lvd_reset;
		st_nxt.cause[rstseq_pkg::CAUSE_WDT]  = st_nxt.cause[rstseq_pkg::CAUSE_WDT] | src.wdt_ovf;
		st_nxt.cause[rstseq_pkg::CAUSE_SW]   = st_nxt.cause[rstseq_pkg::CAUSE_SW] | src.sw_req;
		st_nxt.cause[rstseq_pkg::CAUSE_WAKE] = st_nxt.cause[rstseq_pkg::CAUSE_WAKE] | src.wake;
		if (any_src) begin
			st_nxt.state = rstseq_pkg::RSTSEQ_POWER_UP;
			st_nxt.cnt   = '0;
			// a later source drops the boot loader start
			st_nxt.por_seen = 1'b0;
		end else begin
			case (st_r.state)
				// stays here while supply is low
				rstseq_pkg::RSTSEQ_POWER_UP: begin
					if (!raw_s[3]) begin
						st_nxt.cnt = '0;
					end else if (st_r.cnt == rstseq_pkg::CNT_W'(rstseq_pkg::PWR_STABLE_CYC - 1)) begin
						st_nxt.state = rstseq_pkg::RSTSEQ_PIN_CHECK;
						st_nxt.cnt   = '0;
					end else begin
						st_nxt.cnt = st_r.cnt + 1'b1;
					end
				end
				// hold while enabled pin is low
				rstseq_pkg::RSTSEQ_PIN_CHECK: begin
					if (!(st_r.pin_en && pin_low_s)) begin
						st_nxt.state = rstseq_pkg::RSTSEQ_INIT;
					end
				end
				rstseq_pkg::RSTSEQ_INIT: begin
					st_nxt.ctl.regs_init = 1'b1;
					if (st_r.cnt == rstseq_pkg::CNT_W'(rstseq_pkg::INIT_CYC - 1)) begin
						st_nxt.state         = rstseq_pkg::RSTSEQ_WARMUP;
						st_nxt.cnt           = '0;
						st_nxt.ctl.regs_init = 1'b0;
					end else begin
						st_nxt.cnt = st_r.cnt + 1'b1;
					end
				end
				rstseq_pkg::RSTSEQ_WARMUP: begin
					if (st_r.cnt == rstseq_pkg::CNT_W'(rstseq_pkg::WARMUP_CYC - 1)) begin
						st_nxt.state           = rstseq_pkg::RSTSEQ_RUN;
						st_nxt.ctl.clk_release = 1'b1;
						st_nxt.ctl.sys_reset   = 1'b0;
						st_nxt.ctl.run         = 1'b1;
					end else begin
						st_nxt.cnt = st_r.cnt + 1'b1;
					end
				end
				rstseq_pkg::RSTSEQ_RUN: begin
					st_nxt.ctl.clk_release = 1'b1;
					st_nxt.ctl.sys_reset   = 1'b0;
					st_nxt.ctl.run         = 1'b1;
				end
				default: begin
					st_nxt.state = rstseq_pkg::RSTSEQ_POWER_UP;
					st_nxt.cnt   = '0;
				end
			endcase
		end
		// pin driven low for whole delay phase
		// let go at pin check, so an outside hold can be seen there
		st_nxt.ctl.pin_drive_low = (st_nxt.state == rstseq_pkg::RSTSEQ_POWER_UP);
		if (st_r.por_seen && boot_loader_enable_in) begin
			st_nxt.ctl.start_addr = rstseq_pkg::BOOT_START_ADDR;
		end else begin
			st_nxt.ctl.start_addr = rstseq_pkg::APP_START_ADDR;
		end
	end

	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			st_r.state    <= rstseq_pkg::RSTSEQ_POWER_UP;
			st_r.cnt      <= '0;
			st_r.cause    <= 6'(32'h1 << rstseq_pkg::CAUSE_POR);
			st_r.pin_en   <= rstseq_pkg::PIN_RESET_EN_RST;
			st_r.por_seen <= 1'b1;
			st_r.ctl      <= {1'b1, 1'b1, 1'b0, 1'b0, 1'b0, rstseq_pkg::APP_START_ADDR,
				rstseq_pkg::RESET_VECTOR_ADDR};
			st_r.lvd_irq  <= 1'b0;
			st_r.lvd_stat <= 1'b0;
		end else begin
			st_r <= st_nxt;
		end
	end

	always_comb begin
		sys_reset_out          = st_r.ctl.sys_reset;
		reset_pin_out          = 1'b0;
		reset_pin_oe_out       = st_r.ctl.pin_drive_low;
		regs_init_out          = st_r.ctl.regs_init;
		clk_release_out        = st_r.ctl.clk_release;
		run_out                = st_r.ctl.run;
		start_addr_out         = st_r.ctl.start_addr;
		vector_addr_out        = st_r.ctl.vector_addr;
		reset_cause_status_out = st_r.cause;
		pin_reset_control_out  = st_r.pin_en;
		lvd_irq_out            = st_r.lvd_irq;
		lvd_status_out         = st_r.lvd_stat;
	end

	// pin low for the whole delay phase
	pin_low_a: assert property (@(posedge clk_in) disable iff (reset_in)
		reset_pin_oe_out == (st_r.state == rstseq_pkg::RSTSEQ_POWER_UP))
		else $error("pin drive outside delay phase");
	// watchdog overflow resets and sets its cause flag on the next cycle
	wdt_reset_a: assert property (@(posedge clk_in) disable iff (reset_in)
		watchdog_counter_ovf_in |=> sys_reset_out && reset_cause_status_out[3])
		else $error("watchdog did not reset");
	// no progress past pin check while enabled pin low
	pin_hold_a: assert property (@(posedge clk_in) disable iff (reset_in)
		(st_r.state == rstseq_pkg::RSTSEQ_PIN_CHECK && st_r.pin_en && pin_low_s)
		|=> st_r.state != rstseq_pkg::RSTSEQ_INIT) else $error("left pin check early");
	// power stage held while supply bad
	supply_hold_a: assert property (@(posedge clk_in) disable iff (reset_in)
		(st_r.state == rstseq_pkg::RSTSEQ_POWER_UP && !raw_s[3])
		|=> st_r.state == rstseq_pkg::RSTSEQ_POWER_UP) else $error("left power stage");
	run_clk_a: assert property (@(posedge clk_in) disable iff (reset_in)
		$rose(run_out) |-> clk_release_out && $past(st_r.state) == rstseq_pkg::RSTSEQ_WARMUP)
		else $error("run without warm-up");
	// cause flags never drop during reset
	cause_keep_a: assert property (@(posedge clk_in) disable iff (reset_in)
		sys_reset_out |=> (reset_cause_status_out & $past(reset_cause_status_out))
		== $past(reset_cause_status_out)) else $error("cause flag lost");
	lvd_gate_a: assert property (@(posedge clk_in) disable iff (reset_in)
		lvd_irq_out |-> lvd_status_out && $past(lvd_irq_enable_in))
		else $error("irq without enable");
	vector_fix_a: assert property (@(posedge clk_in) disable iff (reset_in)
		vector_addr_out == rstseq_pkg::RESET_VECTOR_ADDR) else $error("vector moved");
	sw_cov_c:   cover property (@(posedge clk_in) disable iff (reset_in) src.sw_req ##1 sys_reset_out);
	run_cov_c:  cover property (@(posedge clk_in) disable iff (reset_in) $rose(run_out));
	pin_cov_c:  cover property (@(posedge clk_in) disable iff (reset_in)
		st_r.state == rstseq_pkg::RSTSEQ_PIN_CHECK && pin_low_s);
endmodule // rstseq_top
`default_nettype wire

// ==== core/rstseq_pkg.sv ====
// package: constants and carrier types of the system reset sequencer
package rstseq_pkg;
	localparam int unsigned CLK_HZ            = 50000000;
	localparam int unsigned PWR_STABLE_US     = 100;
	localparam int unsigned PWR_STABLE_CYC    = (PWR_STABLE_US * (CLK_HZ / 1000000));
	localparam int unsigned INIT_CYC          = 16;
	localparam int unsigned WARMUP_CYC        = 256;
	localparam int unsigned CNT_W             = 16;
	localparam logic [31:0] RESET_VECTOR_ADDR = 32'h0000_0004;
	localparam logic [31:0] APP_START_ADDR    = 32'h0000_0000;
	localparam logic [31:0] BOOT_START_ADDR   = 32'h1FFF_0000;
	localparam logic        PIN_RESET_EN_RST  = 1'b1;
	localparam int unsigned CAUSE_PIN         = 0;
	localparam int unsigned CAUSE_POR         = 1;
	localparam int unsigned CAUSE_LVD         = 2;
	localparam int unsigned CAUSE_WDT         = 3;
	localparam int unsigned CAUSE_SW          = 4;
	localparam int unsigned CAUSE_WAKE        = 5;
	localparam int unsigned NUM_CAUSES        = 6;

	typedef enum logic [2:0] {
		RSTSEQ_POWER_UP,
		RSTSEQ_PIN_CHECK,
		RSTSEQ_INIT,
		RSTSEQ_WARMUP,
		RSTSEQ_RUN
	} rstseq_state_t;

	// raw event inputs; pin, lvd reset and wake after synchronisation
	typedef struct packed {
		logic pin_low;
		logic por;
		logic lvd_reset;
		logic wdt_ovf;
		logic sw_req;
		logic wake;
	} rstseq_src_t;

	typedef struct packed {
		logic        sys_reset;
		logic        pin_drive_low;
		logic        regs_init;
		logic        clk_release;
		logic        run;
		logic [31:0] start_addr;
		logic [31:0] vector_addr;
	} rstseq_ctl_t;
endpackage : rstseq_pkg

// ==== core/rstseq_sync.sv ====
// two-flop synchroniser for asynchronous pin and analog inputs
`timescale 1ns/100ps
`default_nettype none
module rstseq_sync #(
	parameter int unsigned W        = 1,
	parameter logic [W-1:0] INIT    = '0
) (
	input  wire logic         clk_in,
	input  wire logic         reset_in,
	input  wire logic [W-1:0] async_in,
	output var  logic [W-1:0] sync_out
);
	logic [W-1:0] meta_r;

	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			meta_r   <= INIT;
			sync_out <= INIT;
		end else begin
			meta_r   <= async_in;
			sync_out <= meta_r;
		end
	end
endmodule // rstseq_sync
`default_nettype wire

// ==== test/rstseq_far_model.sv ====
// far side model: pulled-up reset pin wire and software reset request
`timescale 1ns/100ps
`default_nettype none
module rstseq_far_model (
	input  wire logic clk_in,
	input  wire logic pin_oe_in,
	input  wire logic pin_val_in,
	input  wire logic ext_low_in,
	input  wire logic sw_cmd_in,
	output var  logic pin_n_out,
	output var  logic sw_req_out
);
	// pull-up wins only when no party drives the pin low
	always_comb begin
		pin_n_out = (pin_oe_in ? pin_val_in : 1'b1) & ~ext_low_in;
	end
	always_ff @(posedge clk_in) begin
		sw_req_out <= sw_cmd_in;
	end
endmodule // rstseq_far_model
`default_nettype wire

// ==== test/rstseq_top_tb_top.sv ====
// testbench: reset sources, cause flags and release order of the sequencer
`timescale 1ns/100ps
`default_nettype none
module rstseq_top_tb_top;
	logic        clk_in = 1'b0;
	logic        reset_in = 1'b1;
	logic        ext_low = 1'b0;
	logic        sw_cmd = 1'b0;
	logic        sup = 1'b1;
	logic        low_voltage_detector = 1'b0;
	logic        lvd_rst = 1'b0;
	logic        lvd_sel = 1'b0;
	logic        wdt = 1'b0;
	logic        wake = 1'b0;
	logic        pc_wr = 1'b0;
	logic        pc_val = 1'b1;
	logic        irq_en = 1'b0;
	logic        clr = 1'b0;
	logic        boot_loader_enable = 1'b1;
	logic        seen_init = 1'b0;
	logic        pin_n, sw_req, sys_rst, pin_o, pin_oe, init, clk_rel, run, pc_o, irq, lvd_st;
	logic [31:0] start_a, vec_a;
	logic [5:0]  cause;
	int          n_errors = 0;
	int          num_checks = 0;

	always #10 clk_in = ~clk_in;
	always @(posedge clk_in) if (init === 1'b1) seen_init <= 1'b1;

	rstseq_far_model u_rstseq_far_model (.clk_in(clk_in), .pin_oe_in(pin_oe), .pin_val_in(pin_o),
		.ext_low_in(ext_low), .sw_cmd_in(sw_cmd), .pin_n_out(pin_n), .sw_req_out(sw_req));

	rstseq_top u_rstseq_top (.clk_in(clk_in), .reset_in(reset_in), .reset_pin_n_in(pin_n),
		.supply_good_in(sup), .lvd_level_in(low_voltage_detector), .lvd_reset_level_in(lvd_rst),
		.lvd_reset_sel_in(lvd_sel), .watchdog_counter_ovf_in(wdt),
		.sw_system_reset_request_in(sw_req), .deep_sleep_wake_pin_in(wake),
		.boot_loader_enable_in(boot_loader_enable), .pin_reset_control_wr_in(pc_wr),
		.pin_reset_control_in(pc_val), .lvd_irq_enable_in(irq_en), .cause_clear_in(clr),
		.sys_reset_out(sys_rst), .reset_pin_out(pin_o), .reset_pin_oe_out(pin_oe),
		.regs_init_out(init), .clk_release_out(clk_rel), .run_out(run),
		.start_addr_out(start_a), .vector_addr_out(vec_a), .reset_cause_status_out(cause),
		.pin_reset_control_out(pc_o), .lvd_irq_out(irq), .lvd_status_out(lvd_st));

	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		num_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("BAD %s expected %h seen %h", nm, exp, got);
		end
	endtask

	task automatic step(input int n);
		repeat (n) @(posedge clk_in);
		#1;
	endtask

	task automatic wait_run(input int lim);
		for (int i = 0; i < lim && run !== 1'b1; i++) step(1);
		chk("run", 32'h1, {31'h0, run});
	endtask

	task automatic clear_cause();
		@(posedge clk_in) clr <= 1'b1;
		@(posedge clk_in) clr <= 1'b0;
		step(2);
	endtask

	// sources held a few cycles so the synchronisers see them
	task automatic fire(input int k, input int hold);
		@(posedge clk_in);
		case (k)
			0: ext_low <= 1'b1;
			2: begin
				lvd_sel <= 1'b1;
				lvd_rst <= 1'b1;
			end
			3: wdt <= 1'b1;
			4: sw_cmd <= 1'b1;
			default: wake <= 1'b1;
		endcase
		step(hold);
		@(posedge clk_in) {ext_low, lvd_rst, lvd_sel, wdt, sw_cmd, wake} <= 6'h00;
		step(1);
	endtask

	task automatic summarize();
		$display("checks %0d errors %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	initial begin
		repeat (90000) @(posedge clk_in);
		n_errors++;
		$display("BAD watchdog expected finish seen timeout");
		summarize();
	end

	initial begin
		step(10);
		chk("pin_en", 32'h1, {31'h0, pc_o});
		chk("cause_por", 32'h2, {26'h0, cause});
		@(posedge clk_in) reset_in <= 1'b0;
		step(rstseq_pkg::PWR_STABLE_CYC);
		chk("early", 32'h1, {31'h0, sys_rst});
		wait_run(1000);
		chk("init_seen", 32'h1, {31'h0, seen_init});
		chk("clk_rel", 32'h1, {31'h0, clk_rel});
		chk("oe_off", 32'h0, {31'h0, pin_oe});
		chk("boot", rstseq_pkg::BOOT_START_ADDR, start_a);
		chk("vector", rstseq_pkg::RESET_VECTOR_ADDR, vec_a);
		clear_cause();
		chk("clear", 32'h0, {26'h0, cause});
		// pin source held past a full sequence length
		for (int k = 0; k < 6; k++) begin
			if (k == 1) continue;
			fire(k, (k == 0) ? 6000 : 4);
			chk("sys_rst", 32'h1, {31'h0, sys_rst});
			// a held pin is let go at pin check and keeps the block there
			chk("oe_on", (k == 0) ? 32'h0 : 32'h1, {31'h0, pin_oe});
			wait_run(7000);
			chk("cause", 32'h1 << k, {26'h0, cause});
			chk("start0", rstseq_pkg::APP_START_ADDR, start_a);
			clear_cause();
		end
		@(posedge clk_in) low_voltage_detector <= 1'b1;
		step(4);
		chk("lvd_st", 32'h1, {31'h0, lvd_st});
		chk("irq_off", 32'h0, {31'h0, irq});
		@(posedge clk_in) irq_en <= 1'b1;
		step(3);
		chk("irq_on", 32'h1, {31'h0, irq});
		chk("no_rst", 32'h0, {31'h0, sys_rst});
		@(posedge clk_in) low_voltage_detector <= 1'b0;
		@(posedge clk_in) begin
			pc_wr <= 1'b1;
			pc_val <= 1'b0;
		end
		@(posedge clk_in) pc_wr <= 1'b0;
		step(1);
		chk("pin_dis", 32'h0, {31'h0, pc_o});
		@(posedge clk_in) ext_low <= 1'b1;
		step(10);
		chk("pin_ignored", 32'h0, {31'h0, sys_rst});
		@(posedge clk_in) ext_low <= 1'b0;
		@(posedge clk_in) sup <= 1'b0;
		fire(3, 4);
		step(6000);
		chk("low_sup", 32'h1, {31'h0, sys_rst});
		clear_cause();
		chk("clr_refused", 32'h8, {26'h0, cause});
		@(posedge clk_in) sup <= 1'b1;
		wait_run(7000);
		chk("wdt_after", rstseq_pkg::APP_START_ADDR, start_a);
		// second power-on with the boot loader off
		@(posedge clk_in) begin
			boot_loader_enable <= 1'b0;
			reset_in <= 1'b1;
		end
		step(3);
		chk("rst_again", 32'h1, {31'h0, pin_oe});
		@(posedge clk_in) reset_in <= 1'b0;
		wait_run(6000);
		chk("app_start", rstseq_pkg::APP_START_ADDR, start_a);
		chk("por_kept", 32'h2, {26'h0, cause});
		chk("pin_en_rst", 32'h1, {31'h0, pc_o});
		summarize();
	end
endmodule // rstseq_top_tb_top
`default_nettype wire
